// >>> logic/sdrmap_pkg.sv
// Package: register map, field layout and types of the SDRAM map block
`default_nettype none
package sdrmap_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CMD_MODE   = 8'h00;
  localparam logic [7:0] OFS_REFRESH    = 8'h04;
  localparam logic [7:0] OFS_GEOMETRY   = 8'h08;
  localparam logic [7:0] OFS_TIMING_A   = 8'h0C;
  localparam logic [7:0] OFS_TIMING_B   = 8'h10;
  localparam logic [7:0] OFS_TIMING_C   = 8'h14;
  localparam logic [7:0] OFS_LOW_POWER  = 8'h1C;
  localparam logic [7:0] OFS_MEM_TYPE   = 8'h20;
  localparam logic [7:0] OFS_DELAY_INFO = 8'h24;
  localparam logic [7:0] OFS_HIGH_SPEED = 8'h2C;
  localparam logic [7:0] OFS_WP_MODE    = 8'hE4;
  localparam logic [7:0] OFS_WP_STATUS  = 8'hE8;
  // Reset values
  localparam logic [31:0] RST_ZERO      = 32'h0000_0000;
  localparam logic [31:0] RST_GEOMETRY  = 32'h0000_7024;
  localparam logic [31:0] RST_TIMING_A  = 32'h2022_7225;
  localparam logic [31:0] RST_TIMING_B  = 32'h03C8_0808;
  localparam logic [31:0] RST_TIMING_C  = 32'h0000_2062;
  localparam logic [31:0] RST_LOW_POWER = 32'h0001_0000;
  localparam logic [31:0] RST_MEM_TYPE  = 32'h0000_0010;
  localparam logic [31:0] VAL_DELAY     = 32'h0000_0001;
  // Field layout
  localparam int          MODE_W        = 3;
  localparam int          REFRESH_W     = 12;
  localparam int          NC_LSB        = 0;
  localparam int          NR_LSB        = 2;
  localparam int          WP_EN_BIT     = 0;
  localparam int          WP_VIOL_BIT   = 0;
  // Address map
  localparam int          SYS_ADDR_W    = 28;
  localparam int          BYTE_W        = 2;
  localparam int          COL_MIN_W     = 8;
  localparam int          COL_W         = 11;
  localparam int          ROW_MIN_W     = 11;
  localparam int          ROW_W         = 13;
  localparam logic [1:0]  NR_8K         = 2'h2;
  localparam int          BANK_W        = 2;
  // Command modes
  typedef enum logic [MODE_W-1:0] {
    SDRMAP_NORMAL      = 3'h0,
    SDRMAP_NOP         = 3'h1,
    SDRMAP_PRECHARGE   = 3'h2,
    SDRMAP_LOAD_MODE   = 3'h3,
    SDRMAP_AUTOREFRESH = 3'h4,
    SDRMAP_EXT_LOAD    = 3'h5,
    SDRMAP_DEEP_PD     = 3'h6
  } sdrmap_cmd_t;
  // Split memory address
  typedef struct packed {
    logic [BANK_W-1:0] bank_select;
    logic [ROW_W-1:0]  row;
    logic [COL_W-1:0]  col;
    logic [BYTE_W-1:0] byte_off;
  } sdrmap_addr_t;
endpackage : sdrmap_pkg
`default_nettype wire

// >>> logic/sdrmap_regs.sv
// SDRAM address splitter and controller register file behind APB
`default_nettype none
// What this block does
// R1 - Address bits one and zero are byte lane
// R2 - Column sits just above byte lane
// R3 - 2K rows: 11-bit row above column
// R4 - 4K rows: 12-bit row above column
// R5 - 8K rows: 13-bit row above column
// R6 - Two bank bits above row, to pins
// R7 - Registers reached only through APB slave
// R8 - Protect enable blocks command mode writes
// R9 - Command mode picks action of next access
// R10 - Mode field bits 2:0, others zero
module sdrmap_regs
  import sdrmap_pkg::*;
(
  input  wire logic                  CLK_IN,        // System clock
  input  wire logic                  RST_IN,        // Sync reset, high
  input  wire logic                  CE_IN,         // Clock enable
  input  wire logic                  PSEL_IN,       // APB select
  input  wire logic                  PENABLE_IN,    // APB enable
  input  wire logic                  PWRITE_IN,     // APB write
  input  wire logic [7:0]            PADDR_IN,      // APB byte address
  input  wire logic [31:0]           PWDATA_IN,     // APB write data
  output logic      [31:0]           PRDATA_OUT,    // APB read data
  output logic                       PREADY_OUT,    // APB ready
  output logic                       PSLVERR_OUT,   // APB error
  input  wire logic                  ACC_VALID_IN,  // Memory access strobe
  input  wire logic [SYS_ADDR_W-1:0] ACC_ADDR_IN,   // System address
  output sdrmap_addr_t               ACC_MAP_OUT,   // Split address
  output logic      [BANK_W-1:0]     BANK_PIN_OUT,  // Bank address pins
  output sdrmap_cmd_t                ACC_CMD_OUT,   // Command for access
  output logic                       ACC_DONE_OUT,  // Split result valid
  output logic [REFRESH_W-1:0]       REFRESH_OUT,   // Refresh count
  output logic      [31:0]           GEOMETRY_OUT   // Geometry config
);

  // Registers
  logic [MODE_W-1:0]    cmd_mode_r;      // Command mode field
  logic [REFRESH_W-1:0] refresh_r;       // Refresh count
  logic [31:0]          geometry_r;      // Geometry config
  logic [31:0]          timing_a_r;      // Timing word A
  logic [31:0]          timing_b_r;      // Timing word B
  logic [31:0]          timing_c_r;      // Timing word C
  logic [31:0]          low_power_r;     // Low power control
  logic [31:0]          mem_type_r;      // Memory type
  logic [31:0]          high_speed_r;    // High speed control
  logic                 wp_enable_r;     // write_protect_enable
  logic                 wp_viol_r;       // Blocked write seen
  logic [31:0]          prdata_r;        // Read data flop
  sdrmap_addr_t         map_r;           // Split address flop
  sdrmap_cmd_t          cmd_r;           // Command flop
  logic                 done_r;          // Result valid flop

  // Bus phase strobes
  logic                 setup_phase;     // First APB cycle
  logic                 wr_access;       // Write access phase
  logic                 rd_setup;        // Read setup phase
  logic                 protected_hit;   // Write hits guarded reg
  logic                 wr_allowed;      // Guard allows write

  // Width mask of n low bits
  function automatic logic [31:0] low_mask(input int n);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 32; i++)
    begin
      if (i < n)
      begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : low_mask

  // Split a system address by the programmed geometry
  function automatic sdrmap_addr_t split_addr(
    input logic [SYS_ADDR_W-1:0] a,
    input logic [31:0]           geo
  );
    sdrmap_addr_t res;
    logic [1:0]   nc;
    logic [1:0]   nr;
    int           cw;
    int           rw;
    logic [31:0]  wide;
    res  = '0;
    nc   = geo[NC_LSB +: 2];
    nr   = geo[NR_LSB +: 2];
    cw   = COL_MIN_W + int'(nc);
    // Row count: 2K, 4K, 8K; larger codes held at 8K
    rw   = (nr > NR_8K) ? ROW_W : ROW_MIN_W + int'(nr);  // R3 R4 R5
    wide = {{(32-SYS_ADDR_W){1'b0}}, a};
    // Fields stack upward; unused high bits stay zero
    res.byte_off = a[BYTE_W-1:0];                         // R1
    wide = wide >> BYTE_W;
    res.col = COL_W'(wide & low_mask(cw));                // R2
    wide = wide >> cw;
    res.row = ROW_W'(wide & low_mask(rw));                // R3 R4 R5
    wide = wide >> rw;
    res.bank_select = wide[BANK_W-1:0];                   // R6
    return res;
  endfunction : split_addr

  // Map a guarded offset
  function automatic logic is_guarded(input logic [7:0] ofs);
    return (ofs == OFS_CMD_MODE) || (ofs == OFS_REFRESH) ||
           (ofs == OFS_GEOMETRY);
  endfunction : is_guarded

  // Command code to enum; spare code 7 falls back to normal
  function automatic sdrmap_cmd_t decode_cmd(input logic [MODE_W-1:0] code);
    sdrmap_cmd_t c;
    case (code)
      SDRMAP_NOP:         c = SDRMAP_NOP;
      SDRMAP_PRECHARGE:   c = SDRMAP_PRECHARGE;
      SDRMAP_LOAD_MODE:   c = SDRMAP_LOAD_MODE;
      SDRMAP_AUTOREFRESH: c = SDRMAP_AUTOREFRESH;
      SDRMAP_EXT_LOAD:    c = SDRMAP_EXT_LOAD;
      SDRMAP_DEEP_PD:     c = SDRMAP_DEEP_PD;
      default:            c = SDRMAP_NORMAL;  // Normal and spare code
    endcase
    return c;
  endfunction : decode_cmd

  // APB phase decode
  always_comb
  begin
    // Only one transfer is in flight at a time
    setup_phase   = PSEL_IN && !PENABLE_IN;
    wr_access     = PSEL_IN && PENABLE_IN && PWRITE_IN;    // R7
    rd_setup      = setup_phase && !PWRITE_IN;
    protected_hit = wr_access && is_guarded(PADDR_IN);
    wr_allowed    = !wp_enable_r;                          // R8
  end

  // Zero-wait slave, never errors
  // Every transfer ends in its access cycle
  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = 1'b0;

  // Command mode register, guarded
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      cmd_mode_r <= RST_ZERO[MODE_W-1:0];
    end
    else if (CE_IN && wr_access && PADDR_IN == OFS_CMD_MODE &&
             wr_allowed)                                   // R8
    begin
      // Upper write bits are dropped here
      cmd_mode_r <= PWDATA_IN[MODE_W-1:0];                 // R10
    end
  end

  // Refresh count and geometry, guarded
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      refresh_r  <= RST_ZERO[REFRESH_W-1:0];
      geometry_r <= RST_GEOMETRY;
    end
    else if (CE_IN && wr_access && wr_allowed)
    begin
      // Only the addressed register moves
      if (PADDR_IN == OFS_REFRESH)
      begin
        // Only the count field is kept
        refresh_r <= PWDATA_IN[REFRESH_W-1:0];
      end
      if (PADDR_IN == OFS_GEOMETRY)
      begin
        geometry_r <= PWDATA_IN;
      end
    end
  end

  // Unguarded configuration words
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      timing_a_r   <= RST_TIMING_A;
      timing_b_r   <= RST_TIMING_B;
      timing_c_r   <= RST_TIMING_C;
      low_power_r  <= RST_LOW_POWER;
      mem_type_r   <= RST_MEM_TYPE;
      high_speed_r <= RST_ZERO;
    end
    // Timing, power and type words have no guard
    else if (CE_IN && wr_access)
    begin
      case (PADDR_IN)
        OFS_TIMING_A:   timing_a_r   <= PWDATA_IN;
        OFS_TIMING_B:   timing_b_r   <= PWDATA_IN;
        OFS_TIMING_C:   timing_c_r   <= PWDATA_IN;
        OFS_LOW_POWER:  low_power_r  <= PWDATA_IN;
        OFS_MEM_TYPE:   mem_type_r   <= PWDATA_IN;
        OFS_HIGH_SPEED: high_speed_r <= PWDATA_IN;
        default:        ;  // Other offsets ignored
      endcase
    end
  end

  // Write protection enable
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      wp_enable_r <= 1'b0;
    end
    else if (CE_IN && wr_access && PADDR_IN == OFS_WP_MODE)
    begin
      wp_enable_r <= PWDATA_IN[WP_EN_BIT];
    end
  end

  // Violation flag: set by blocked write, read clears, set wins
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      wp_viol_r <= 1'b0;
    end
    else if (CE_IN)
    begin
      // A blocked write outranks the clear
      if (protected_hit && !wr_allowed)                    // R8
      begin
        wp_viol_r <= 1'b1;
      end
      else if (PSEL_IN && PENABLE_IN && !PWRITE_IN &&
               PADDR_IN == OFS_WP_STATUS)
      begin
        wp_viol_r <= 1'b0;
      end
    end
  end

  // Read data captured in setup phase
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      prdata_r <= RST_ZERO;
    end
    // Capture early so read data leaves a flop
    else if (CE_IN && rd_setup)
    begin
      case (PADDR_IN)
        OFS_CMD_MODE:   prdata_r <= {29'h0000_0000, cmd_mode_r};  // R10
        OFS_REFRESH:    prdata_r <= {20'h0_0000, refresh_r};
        OFS_GEOMETRY:   prdata_r <= geometry_r;
        OFS_TIMING_A:   prdata_r <= timing_a_r;
        OFS_TIMING_B:   prdata_r <= timing_b_r;
        OFS_TIMING_C:   prdata_r <= timing_c_r;
        OFS_LOW_POWER:  prdata_r <= low_power_r;
        OFS_MEM_TYPE:   prdata_r <= mem_type_r;
        OFS_DELAY_INFO: prdata_r <= VAL_DELAY;
        OFS_HIGH_SPEED: prdata_r <= high_speed_r;
        OFS_WP_MODE:    prdata_r <= {31'h0000_0000, wp_enable_r};
        OFS_WP_STATUS:  prdata_r <= {31'h0000_0000, wp_viol_r};
        default:        prdata_r <= RST_ZERO;  // Unmapped reads zero
      endcase
    end
  end

  // Memory access split and command stamp
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      map_r  <= '0;
      cmd_r  <= SDRMAP_NORMAL;
      done_r <= 1'b0;
    end
    else if (CE_IN)
    begin
      done_r <= ACC_VALID_IN;
      if (ACC_VALID_IN)
      begin
        map_r <= split_addr(ACC_ADDR_IN, geometry_r);     // R1 R2 R6
        // Mode in force when the access arrives
        cmd_r <= decode_cmd(cmd_mode_r);                  // R9
      end
    end
  end

  // Outputs
  assign PRDATA_OUT   = prdata_r;
  assign ACC_MAP_OUT  = map_r;
  assign BANK_PIN_OUT = map_r.bank_select;                 // R6
  assign ACC_CMD_OUT  = cmd_r;
  assign ACC_DONE_OUT = done_r;
  assign REFRESH_OUT  = refresh_r;
  assign GEOMETRY_OUT = geometry_r;

endmodule : sdrmap_regs
`default_nettype wire

// >>> verif/sdrmap_regs_assertions.sv
// Checker for the SDRAM map block, bound to its ports
`default_nettype none
module sdrmap_regs_chk
  import sdrmap_pkg::*;
(
  input wire logic                  CLK_IN,       // Clock
  input wire logic                  RST_IN,       // Reset
  input wire logic                  CE_IN,        // Clock enable
  input wire logic                  PSEL_IN,      // APB select
  input wire logic                  PENABLE_IN,   // APB enable
  input wire logic                  PWRITE_IN,    // APB write
  input wire logic [7:0]            PADDR_IN,     // APB address
  input wire logic [31:0]           PRDATA_OUT,   // APB read data
  input wire logic                  PREADY_OUT,   // APB ready
  input wire logic                  PSLVERR_OUT,  // APB error
  input wire logic                  ACC_VALID_IN, // Access strobe
  input wire logic [SYS_ADDR_W-1:0] ACC_ADDR_IN,  // System address
  input wire sdrmap_addr_t          ACC_MAP_OUT,  // Split address
  input wire logic [BANK_W-1:0]     BANK_PIN_OUT, // Bank pins
  input wire logic                  ACC_DONE_OUT, // Result valid
  input wire logic [31:0]           GEOMETRY_OUT  // Geometry register
);
  int          cw;    // Column width
  int          rw;    // Row width
  logic [27:0] e_col; // Expected column
  logic [27:0] e_row; // Expected row
  logic [27:0] e_bk;  // Expected bank
  // Expected fields from the live geometry
  always_comb
  begin
    cw = 8 + int'(GEOMETRY_OUT[1:0]);
    rw = (GEOMETRY_OUT[3:2] > 2'h1) ? 13 :
         11 + int'(GEOMETRY_OUT[3:2]);
    e_col = (ACC_ADDR_IN >> 2) & ((28'h1 << cw) - 28'h1);
    e_row = (ACC_ADDR_IN >> (2 + cw)) & ((28'h1 << rw) - 28'h1);
    e_bk = (ACC_ADDR_IN >> (2 + cw + rw)) & 28'h3;
  end
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  sequence s_acc;
    ACC_VALID_IN && CE_IN;
  endsequence
  sequence s_rd_mode;
    PSEL_IN && !PENABLE_IN && !PWRITE_IN && CE_IN && PADDR_IN == OFS_CMD_MODE;
  endsequence
  a_done_next: assert property (s_acc |=> ACC_DONE_OUT)
    else $error("done missing after access");
  a_byte_lane: assert property (s_acc |=>
    ACC_MAP_OUT.byte_off == $past(ACC_ADDR_IN[1:0]))
    else $error("byte lane wrong");
  a_col_field: assert property (s_acc |=>
    ACC_MAP_OUT.col == $past(e_col[10:0])) else $error("column wrong");
  a_row_field: assert property (s_acc |=>
    ACC_MAP_OUT.row == $past(e_row[12:0])) else $error("row wrong");
  a_bank_field: assert property (s_acc |=>
    ACC_MAP_OUT.bank_select == $past(e_bk[1:0])) else $error("bank wrong");
  a_bank_pins: assert property (ACC_DONE_OUT |->
    BANK_PIN_OUT == ACC_MAP_OUT.bank_select) else $error("pins wrong");
  a_map_hold: assert property (!(ACC_VALID_IN && CE_IN) |=>
    $stable(ACC_MAP_OUT)) else $error("map moved without access");
  a_apb_ok: assert property (PREADY_OUT && !PSLVERR_OUT)
    else $error("apb answer wrong");
  a_mode_zero: assert property (s_rd_mode |=>
    PRDATA_OUT[31:3] == 29'h0) else $error("mode upper bits set");
endmodule : sdrmap_regs_chk
bind sdrmap_regs sdrmap_regs_chk sdrmap_regs_chk_inst (.*);
`default_nettype wire

// >>> verif/sdrmap_sdram_model.sv
// Behavioural SDRAM device counting issued accesses and noting banks opened
`default_nettype none
module sdrmap_sdram_model
(
  input  wire logic       clk_in,    // Clock
  input  wire logic       rst_in,    // Sync reset
  input  wire logic       done_in,   // Access issued
  input  wire logic [1:0] bank_in,   // Bank pins
  output logic      [31:0] count_out, // Accesses taken
  output logic      [3:0]  banks_out  // Banks opened
);
  // Take each access and note which bank it opened
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      count_out <= 32'h0000_0000;
      banks_out <= 4'h0;
    end
    else if (done_in)
    begin
      count_out <= count_out + 32'h0000_0001;
      banks_out <= banks_out | (4'h1 << bank_in);
    end
  end
endmodule : sdrmap_sdram_model
`default_nettype wire

// >>> verif/test_sdrmap_regs.sv
// Self-checking bench for the SDRAM map block
`default_nettype none
module test_sdrmap_regs
  import sdrmap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic vld = 1'b0, ce = 1'b1, rdy, err, done;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, geo, cnt;
  logic [31:0] seed = 32'h6d41_85c1;
  logic [27:0] addr = 28'h000_0000;
  logic [1:0] bank;
  logic [3:0] banks;
  logic [11:0] refr;
  sdrmap_addr_t map;
  sdrmap_cmd_t cmd;
  logic [30:0] q_acc[$];
  logic [31:0] q_rd[$];
  int failures = 0, checks_done = 0, cyc = 0;
  localparam logic [7:0] OFS[14] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10,
    8'h14, 8'h1C, 8'h20, 8'h24, 8'h2C, 8'hE4, 8'hE8, 8'h18, 8'hEC};
  localparam logic [31:0] RV[14] = '{RST_ZERO, RST_ZERO, RST_GEOMETRY,
    RST_TIMING_A, RST_TIMING_B, RST_TIMING_C, RST_LOW_POWER, RST_MEM_TYPE,
    VAL_DELAY, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO};
  always #10 clk = ~clk;
  sdrmap_regs sdrmap_regs_inst (.CLK_IN(clk), .RST_IN(rst), .CE_IN(ce),
    .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(rdy),
    .PSLVERR_OUT(err), .ACC_VALID_IN(vld), .ACC_ADDR_IN(addr),
    .ACC_MAP_OUT(map), .BANK_PIN_OUT(bank), .ACC_CMD_OUT(cmd),
    .ACC_DONE_OUT(done), .REFRESH_OUT(refr), .GEOMETRY_OUT(geo));
  sdrmap_sdram_model sdrmap_sdram_model_inst (.clk_in(clk), .rst_in(rst),
    .done_in(done), .bank_in(bank), .count_out(cnt), .banks_out(banks));
  // Compare one seen value with its expectation
  task automatic check(input string n, input logic [31:0] s, e);
    checks_done++;
    if (s !== e)
    begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : check
  // Report counts and verdict, then stop
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  // Xorshift source for access addresses
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // Expected command and split address
  function automatic logic [30:0] xmap(input logic [27:0] a,
                                       input int nc, nr, m);
    int cw, rw;
    sdrmap_addr_t r;
    cw = 8 + nc;
    rw = nr > 1 ? 13 : 11 + nr;
    r = '0;
    r.byte_off = a[1:0];
    r.col = 11'((a >> 2) & ((28'h1 << cw) - 1));
    r.row = 13'((a >> (2 + cw)) & ((28'h1 << rw) - 1));
    r.bank_select = 2'(a >> (2 + cw + rw));
    return {m[2:0], r};
  endfunction : xmap
  // One APB transfer, setup then access
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk) #1;
    psel = 1'b1;
    pwr = w;
    paddr = a;
    pwdata = d;
    @(posedge clk) #1;
    pen = 1'b1;
    @(posedge clk) #1;
    psel = 1'b0;
    pen = 1'b0;
    paddr = ~a;
    pwdata = ~d;
  endtask : apb
  // Read with expectation noted first
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q_rd.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd
  // Back-to-back random accesses
  task automatic burst(input int n, nc, nr, m);
    repeat (n)
    begin
      @(posedge clk) #1;
      vld = 1'b1;
      addr = 28'(xs());
      q_acc.push_back(xmap(addr, nc, nr, m));
    end
    @(posedge clk) #1;
    vld = 1'b0;
    addr = ~addr;
  endtask : burst
  // Result watcher and hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (done === 1'b1)
      check("access", {1'b0, cmd, map},
            {1'b0, q_acc.pop_front()});
    if (psel && pen)
      check("answer", {30'h0000_0000, err, rdy}, 32'h0000_0001);
    if (psel && pen && !pwr)
      check("read", prdata, q_rd.pop_front());
    if (cyc == 3000)
    begin
      failures++;
      print_verdict();
    end
  end
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    foreach (OFS[i]) rd(OFS[i], RV[i]);
    apb(1'b1, OFS_DELAY_INFO, 32'hFFFF_FFFF);
    rd(OFS_DELAY_INFO, VAL_DELAY);
    apb(1'b1, 8'h18, 32'hFFFF_FFFF);
    rd(8'h18, RST_ZERO);
    apb(1'b1, OFS_REFRESH, 32'hFFFF_FFFF);
    rd(OFS_REFRESH, 32'h0000_0FFF);
    $display("test registers done");
    for (int c = 0; c < 4; c++)
      for (int r = 0; r < 3; r++)
      begin
        apb(1'b1, OFS_GEOMETRY, RST_GEOMETRY & 32'hFFFF_FFF0 | (r << 2) | c);
        burst(6, c, r, 0);
      end
    $display("test geometry done");
    for (int m = 0; m < 7; m++)
    begin
      apb(1'b1, OFS_CMD_MODE, 32'hFFFF_FFF8 | m);
      rd(OFS_CMD_MODE, m);
      burst(1, 3, 2, m);
    end
    $display("test modes done");
    apb(1'b1, OFS_WP_MODE, 32'h0000_0001);
    apb(1'b1, OFS_CMD_MODE, 32'h0000_0002);
    apb(1'b1, OFS_REFRESH, 32'h0000_0000);
    apb(1'b1, OFS_GEOMETRY, RST_GEOMETRY);
    rd(OFS_CMD_MODE, 32'h0000_0006);
    burst(1, 3, 2, 6);
    check("refresh", {20'h0_0000, refr}, 32'h0000_0FFF);
    check("geometry", geo, {RST_GEOMETRY[31:4], 4'hB});
    rd(OFS_WP_STATUS, 32'h0000_0001);
    rd(OFS_WP_STATUS, 32'h0000_0000);
    apb(1'b1, OFS_WP_MODE, 32'h0000_0000);
    apb(1'b1, OFS_CMD_MODE, 32'h0000_0000);
    rd(OFS_CMD_MODE, 32'h0000_0000);
    $display("test protect done");
    ce = 1'b0;
    apb(1'b1, OFS_REFRESH, 32'h0000_0000);
    ce = 1'b1;
    check("frozen", {20'h0_0000, refr}, 32'h0000_0FFF);
    $display("test enable done");
    repeat (2) @(posedge clk);
    check("count", cnt, 32'h0000_0050);
    check("banks", {28'h000_0000, banks}, 32'h0000_000F);
    print_verdict();
  end
endmodule : test_sdrmap_regs
`default_nettype wire
